// *** core/rtc_bus_top.sv ***
// Real-time clock with alarm and periodic interrupts on an Avalon-MM slave.
// Assumes one 100 MHz clock; osc_in and power_fail are asynchronous pins.
// Functional notes
// - Register data is eight bits wide.
// - Eight counters, each addressable for read/write.
// - Counters advance from divided crystal pulses.
// - Four crystal settings keep timebase correct.
// - Address latch strobe for multiplexed hosts.
// - Periodic interrupt at six selectable rates.
// - Host-loaded alarm storage feeds comparator.
// - Alarm fires when time equals alarm.
// - Status register names the interrupt source.
// - Power loss blocks bus, time keeps running.
// - Reading hundredths latches all counters.
// - Hours in 12- or 24-hour format.
// - Full calendar with leap-year correction.
// - Hundredths up to two-digit years.
// - Command register write-only at 11h.
`timescale 1ns/10ps
module rtc_bus_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic [6:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic addr_latch,
    input wire logic osc_in,
    input wire logic power_fail,
    output logic irq,
    output logic irq_alarm
);
    import rtc_pkg::*;

    logic pf_s1, pf_s2;
    bus_state_t state, next_state;
    logic next_wait;
    logic [31:0] next_rdata;
    logic [4:0] latched_idx, next_latched, idx;
    logic req, prep, commit, wr_ok, rd_commit;
    logic [7:0] wd, rd_byte;
    cmd_t cmd, next_cmd;
    logic [7:0] intctl, next_intctl;
    logic [6:0][7:0] alarm, next_alarm;
    logic [6:0] status, next_status, set_bits, clr_bits;
    rtc_time_t now, snap, next_snap;
    logic [N_PERIODIC-1:0] carry;
    logic tick, cal_we, match, alarm_hit, next_irq;
    logic [7:0] cal_wdata;

    // Counter byte as the host sees it, honouring the hour format
    function automatic logic [7:0] shown(input rtc_time_t t, input logic [2:0] i,
                                         input logic h24);
        logic [7:0] h;
        h = t.hour;
        if (i == IDX_HOUR[2:0] && !h24) begin
            if (h == 8'h00) begin
                return 8'h8C & 8'h7F;
            end else if (h > 8'h0C) begin
                return (h - 8'h0C) | 8'h80;
            end else if (h == 8'h0C) begin
                return 8'h8C;
            end
            return h;
        end
        return t[{i, 3'h0} +: 8];
    endfunction

    // Host hour byte to internal 24-hour binary
    function automatic logic [7:0] to_h24(input logic [7:0] d, input logic h24);
        logic [7:0] base;
        base = {3'h0, d[4:0]};
        if (h24) begin
            return d;
        end
        if (base == 8'h0C) begin
            base = 8'h00;
        end
        return d[HOUR_PM_BIT] ? base + 8'h0C : base;
    endfunction

    // Power-fail pin synchroniser
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pf_s1 <= 1'b0;
            pf_s2 <= 1'b0;
        end else begin
            pf_s1 <= power_fail;
            pf_s2 <= pf_s1;
        end
    end

    rtc_timebase u_timebase (
        .clk(clk),
        .reset(reset),
        .osc_in(osc_in),
        .run(cmd.run),
        .freq(cmd.freq),
        .tick(tick)
    );

    rtc_calendar u_calendar (
        .clk(clk),
        .reset(reset),
        .tick(tick),
        .we(cal_we),
        .widx(idx[2:0]),
        .wdata(cal_wdata),
        .now(now),
        .carry(carry)
    );

    // Access decode; the latched index serves multiplexed address/data hosts
    assign idx = intctl[INT_MUX_BIT] ? latched_idx : avs_address[6:2];
    assign req = avs_read | avs_write;
    assign prep = (state == BUS_IDLE) && req;
    assign commit = (state == BUS_DONE) && req;
    assign wd = avs_writedata[7:0];
    assign wr_ok = commit && avs_write && avs_byteenable[0] && !pf_s2;
    assign rd_commit = commit && avs_read && !pf_s2;
    assign cal_we = wr_ok && (idx <= IDX_WDAY);
    assign cal_wdata = (idx == IDX_HOUR) ? to_h24(wd, cmd.h24) : wd;

    // Read multiplexer; hundredths comes live, the other counters from the snapshot
    always_comb begin
        rd_byte = 8'h00;
        if (idx == IDX_HSEC) begin
            rd_byte = now.hsec;
        end else if (idx <= IDX_WDAY) begin
            rd_byte = shown(snap, idx[2:0], cmd.h24);
        end else if (idx <= IDX_ALARM_LAST) begin
            rd_byte = alarm[idx[2:0]];
        end else if (idx == IDX_STATUS) begin
            rd_byte = {|status, status};
        end else if (idx == IDX_INTCTL) begin
            rd_byte = intctl;
        end
        // Command register and unmapped indices read as zero
    end

    // Bus handshake: one wait cycle, then the access completes
    always_comb begin
        next_state = state;
        next_wait = avs_waitrequest;
        next_rdata = avs_readdata;
        case (state)
            BUS_IDLE: begin
                if (req) begin
                    next_state = BUS_DONE;
                    next_wait = 1'b0;
                    // No data driven while the supply is failing
                    next_rdata = (pf_s2 || !avs_read) ? 32'h0 : {24'h0, rd_byte};
                end
            end
            BUS_DONE: begin
                next_state = BUS_IDLE;
                next_wait = 1'b1;
            end
            default: begin
                next_state = BUS_IDLE;
                next_wait = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            state <= next_state;
            avs_waitrequest <= next_wait;
            avs_readdata <= next_rdata;
        end
    end

    // Host-written registers and the read snapshot
    always_comb begin
        next_cmd = cmd;
        next_intctl = intctl;
        next_alarm = alarm;
        next_snap = snap;
        next_latched = latched_idx;
        if (addr_latch) begin
            next_latched = avs_address[6:2];
        end
        if (prep && avs_read && !pf_s2 && idx == IDX_HSEC) begin
            next_snap = now;
        end
        if (wr_ok) begin
            if (idx == IDX_CMD) begin
                next_cmd = cmd_t'(wd[5:0]);
            end else if (idx == IDX_INTCTL) begin
                next_intctl = wd;
            end else if (idx >= IDX_ALARM && idx <= IDX_ALARM_LAST) begin
                next_alarm[idx[2:0]] = wd;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmd <= cmd_t'(CMD_RESET);
            intctl <= INTCTL_RESET;
            alarm <= '0;
            snap <= '0;
            latched_idx <= 5'h00;
        end else begin
            cmd <= next_cmd;
            intctl <= next_intctl;
            alarm <= next_alarm;
            snap <= next_snap;
            latched_idx <= next_latched;
        end
    end

    // Alarm comparator against the displayed form of the running time
    always_comb begin
        match = 1'b1;
        for (int i = 0; i < 7; i++) begin
            if (alarm[i] != shown(now, 3'(i), cmd.h24)) begin
                match = 1'b0;
            end
        end
    end
    // Only checked right after a step, so a held match fires once
    assign alarm_hit = carry[0] && match;

    // Sticky sources; a set in the clearing cycle survives the clear
    // Clearing only the bits the host was given keeps a late source from being lost
    always_comb begin
        set_bits = {alarm_hit & intctl[INT_ALARM_BIT], carry & intctl[N_PERIODIC-1:0]};
        clr_bits = (rd_commit && idx == IDX_STATUS) ? avs_readdata[6:0] : 7'h00;
        next_status = (status & ~clr_bits) | set_bits;
        next_irq = cmd.int_en && (|status);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status <= STATUS_RESET;
            irq <= 1'b0;
            irq_alarm <= 1'b0;
        end else begin
            status <= next_status;
            irq <= next_irq;
            irq_alarm <= status[INT_ALARM_BIT];
        end
    end

    property p_wait_one;
        @(posedge clk) disable iff (reset) prep |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("access not answered in one cycle");

    property p_pf_read_zero;
        @(posedge clk) disable iff (reset) (prep && pf_s2) |=> avs_readdata == 32'h0;
    endproperty
    a_pf_read_zero: assert property (p_pf_read_zero) else $error("data driven in power fail");

    property p_pf_no_write;
        @(posedge clk) disable iff (reset)
            (commit && avs_write && pf_s2) |=> ($stable(cmd) && $stable(alarm) && $stable(intctl));
    endproperty
    a_pf_no_write: assert property (p_pf_no_write) else $error("write taken in power fail");

    property p_cmd_unreadable;
        @(posedge clk) disable iff (reset) (prep && idx == IDX_CMD) |=> avs_readdata == 32'h0;
    endproperty
    a_cmd_unreadable: assert property (p_cmd_unreadable) else $error("command register read");

    property p_snapshot;
        @(posedge clk) disable iff (reset)
            (prep && avs_read && !pf_s2 && idx == IDX_HSEC) |=> snap == $past(now);
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("snapshot not taken");

    property p_alarm_flag;
        @(posedge clk) disable iff (reset)
            (carry[0] && match && intctl[INT_ALARM_BIT]) |=> status[INT_ALARM_BIT] ##1 irq_alarm;
    endproperty
    a_alarm_flag: assert property (p_alarm_flag) else $error("alarm not flagged");

    property p_irq_follows;
        @(posedge clk) disable iff (reset) (cmd.int_en && |status) |=> irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("interrupt not raised");

    property p_periodic;
        @(posedge clk) disable iff (reset) (carry[2] && intctl[2]) |=> status[2];
    endproperty
    a_periodic: assert property (p_periodic) else $error("periodic source lost");
endmodule

// *** core/rtc_pkg.sv ***
// Shared constants, types and helpers for the bus real-time clock.
// Assumes a single 100 MHz clock domain and a 32-bit Avalon-MM host.
package rtc_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [4:0] IDX_HSEC = 5'h00;
    localparam logic [4:0] IDX_HOUR = 5'h01;
    localparam logic [4:0] IDX_WDAY = 5'h07;
    localparam logic [4:0] IDX_ALARM = 5'h08;
    localparam logic [4:0] IDX_ALARM_LAST = 5'h0E;
    localparam logic [4:0] IDX_STATUS = 5'h10;
    localparam logic [4:0] IDX_CMD = 5'h11;
    localparam logic [4:0] IDX_INTCTL = 5'h12;
    // Field positions
    localparam int HOUR_PM_BIT = 7;
    localparam int INT_ALARM_BIT = 6;
    localparam int INT_MUX_BIT = 7;
    localparam int N_PERIODIC = 6;
    // Reset values
    localparam logic [5:0] CMD_RESET = 6'h00;
    localparam logic [7:0] INTCTL_RESET = 8'h00;
    localparam logic [6:0] STATUS_RESET = 7'h00;
    localparam logic [7:0] DATE_RESET = 8'h01;
    localparam logic [7:0] MONTH_RESET = 8'h01;
    // Crystal rates and the counter tick rate in Hz
    localparam logic [22:0] XTAL_32K = 23'h008000;
    localparam logic [22:0] XTAL_1M = 23'h100000;
    localparam logic [22:0] XTAL_2M = 23'h200000;
    localparam logic [22:0] XTAL_4M = 23'h400000;
    localparam logic [22:0] TICK_HZ = 23'h000064;

    typedef struct packed {
        logic test;
        logic int_en;
        logic run;
        logic h24;
        logic [1:0] freq;
    } cmd_t;

    // Byte i of the struct is counter index i
    typedef struct packed {
        logic [7:0] wday;
        logic [7:0] year;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] hsec;
    } rtc_time_t;

    typedef enum logic {BUS_IDLE = 1'b0, BUS_DONE = 1'b1} bus_state_t;

    // Crystal frequency for a command register setting
    function automatic logic [22:0] xtal_hz(input logic [1:0] sel);
        case (sel)
            2'h0: return XTAL_32K;
            2'h1: return XTAL_1M;
            2'h2: return XTAL_2M;
            default: return XTAL_4M;
        endcase
    endfunction
endpackage

// *** core/rtc_timebase.sv ***
// Hundredths-of-a-second tick generator from the crystal input.
// Assumes osc_in is asynchronous and well below half the system clock.
`timescale 1ns/10ps
module rtc_timebase (
    input wire logic clk,
    input wire logic reset,
    input wire logic osc_in,
    input wire logic run,
    input wire logic [1:0] freq,
    output logic tick
);
    import rtc_pkg::*;
    logic osc_s1, osc_s2, osc_s3;
    logic osc_rise;
    logic [22:0] acc, next_acc;
    logic next_tick;

    // Two-stage synchroniser plus one stage for edge detection
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_s3 <= 1'b0;
        end else begin
            osc_s1 <= osc_in;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
        end
    end
    assign osc_rise = osc_s2 & ~osc_s3;

    // Fractional divider: exact average rate, since 32768 is not a multiple of 100
    always_comb begin
        next_acc = acc;
        next_tick = 1'b0;
        // A stopped divider restarts from zero, else a residue from a faster setting bursts ticks
        if (!run) begin
            next_acc = '0;
        end else if (osc_rise) begin
            if (acc + TICK_HZ >= xtal_hz(freq)) begin
                next_acc = acc + TICK_HZ - xtal_hz(freq);
                next_tick = 1'b1;
            end else begin
                next_acc = acc + TICK_HZ;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            acc <= '0;
            tick <= 1'b0;
        end else begin
            acc <= next_acc;
            tick <= next_tick;
        end
    end

    property p_tick_cause;
        @(posedge clk) disable iff (reset) tick |-> $past(osc_rise && run);
    endproperty
    a_tick_cause: assert property (p_tick_cause) else $error("tick without crystal edge");
endmodule

// *** core/rtc_calendar.sv ***
// Counter chain from hundredths to years with full calendar.
// Assumes writes arrive with hours already in 24-hour binary form.
`timescale 1ns/10ps
module rtc_calendar (
    input wire logic clk,
    input wire logic reset,
    input wire logic tick,
    input wire logic we,
    input wire logic [2:0] widx,
    input wire logic [7:0] wdata,
    output rtc_pkg::rtc_time_t now,
    output logic [rtc_pkg::N_PERIODIC-1:0] carry
);
    import rtc_pkg::*;
    rtc_time_t next_now;
    logic [N_PERIODIC-1:0] next_carry;

    // Month length with leap years every fourth year of the two-digit range
    function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
        case (m)
            8'h02: return (y[1:0] == 2'h0) ? 8'h1D : 8'h1C;
            8'h04, 8'h06, 8'h09, 8'h0B: return 8'h1E;
            default: return 8'h1F;
        endcase
    endfunction

    // Ripple carries; carry bits mark 100 Hz, 10 Hz, s, min, h, day
    always_comb begin
        next_now = now;
        next_carry = '0;
        if (tick) begin
            next_carry[0] = 1'b1;
            next_now.hsec = now.hsec + 8'h01;
            if (now.hsec % 8'h0A == 8'h09) begin
                next_carry[1] = 1'b1;
            end
            if (now.hsec == 8'h63) begin
                next_now.hsec = 8'h00;
                next_carry[2] = 1'b1;
                next_now.sec = now.sec + 8'h01;
                if (now.sec == 8'h3B) begin
                    next_now.sec = 8'h00;
                    next_carry[3] = 1'b1;
                    next_now.min = now.min + 8'h01;
                    if (now.min == 8'h3B) begin
                        next_now.min = 8'h00;
                        next_carry[4] = 1'b1;
                        next_now.hour = now.hour + 8'h01;
                        if (now.hour == 8'h17) begin
                            next_now.hour = 8'h00;
                            next_carry[5] = 1'b1;
                            next_now.wday = (now.wday == 8'h06) ? 8'h00 : now.wday + 8'h01;
                            next_now.date = now.date + 8'h01;
                            if (now.date >= month_days(now.month, now.year)) begin
                                next_now.date = 8'h01;
                                next_now.month = now.month + 8'h01;
                                if (now.month == 8'h0C) begin
                                    next_now.month = 8'h01;
                                    next_now.year = (now.year == 8'h63) ? 8'h00
                                        : now.year + 8'h01;
                                end
                            end
                        end
                    end
                end
            end
        end
        // A host write to one counter overrides its own step
        if (we) begin
            next_now[{widx, 3'h0} +: 8] = wdata;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            now <= '{wday: 8'h00, year: 8'h00, date: DATE_RESET, month: MONTH_RESET,
                     sec: 8'h00, min: 8'h00, hour: 8'h00, hsec: 8'h00};
            carry <= '0;
        end else begin
            now <= next_now;
            carry <= next_carry;
        end
    end

    property p_hsec_wrap;
        @(posedge clk) disable iff (reset)
            (tick && !we && now.hsec == 8'h63) |=> (now.hsec == 8'h00 && carry[2]);
    endproperty
    a_hsec_wrap: assert property (p_hsec_wrap) else $error("hundredths did not carry");
endmodule

// *** verification/xtal_source.sv ***
// Crystal stand-in driving the oscillator pin of the real-time clock.
// Assumes the bench needs a free-running source with no phase tie to clk.
`timescale 1ns/10ps
module xtal_source #(
    parameter real HALF_NS = 20.17
) (
    output logic osc_in
);
    // Start low so the first edge seen by the synchroniser is a clean rise
    initial begin
        osc_in = 1'b0;
    end

    // Runs fast and off the clk grid so ticks come quickly and drift in phase
    always begin
        #(HALF_NS) osc_in = ~osc_in;
    end
endmodule

// *** verification/bus_rtc_alarm_periodic_tb.sv ***
// Self-checking bench for the real-time clock behind an Avalon-MM slave.
// Assumes the design files in core/ and the crystal model in verification/.
`timescale 1ns/10ps
module bus_rtc_alarm_periodic_tb;
    import rtc_pkg::*;
    logic clk, reset, avs_read, avs_write, avs_waitrequest, addr_latch, osc_in;
    logic power_fail, irq, irq_alarm;
    logic [6:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    int num_errors = 0;
    int tests_run = 0;

    rtc_bus_top u_dut (.clk(clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .addr_latch(addr_latch), .osc_in(osc_in),
        .power_fail(power_fail), .irq(irq), .irq_alarm(irq_alarm));
    xtal_source u_xtal (.osc_in(osc_in));

    // 100 MHz clock
    always begin
        #5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // One bus access; only the watchdog ends a wait for the answer
    task automatic bus(input logic wr, input logic [4:0] idx, input logic [7:0] wd,
                       input logic [3:0] be, output logic [31:0] rd);
        @(posedge clk);
        avs_address <= {idx, 2'h0};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h000000, wd};
        avs_byteenable <= be;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        chk("readdata upper", {8'h00, rd[31:8]}, 32'h0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic reg_write(input logic [4:0] idx, input logic [7:0] d);
        logic [31:0] v;
        bus(1'b1, idx, d, 4'hF, v);
    endtask

    task automatic rd_chk(input string what, input logic [4:0] idx, input logic [7:0] exp);
        logic [31:0] v;
        bus(1'b0, idx, 8'h00, 4'hF, v);
        chk(what, v, {24'h000000, exp});
    endtask

    // Reset values, write-only command, unmapped hole
    task automatic t_reset_map();
        for (int i = 0; i < 8; i++) begin
            rd_chk("counter reset", 5'(i), (i == 4 || i == 5) ? 8'h01 : (i == 1) ? 8'h0C : 8'h00);
        end
        rd_chk("status reset", IDX_STATUS, 8'h00);
        reg_write(IDX_CMD, 8'h24);
        rd_chk("command read", IDX_CMD, 8'h00);
        reg_write(5'h0F, 8'h5A);
        rd_chk("hole read", 5'h0F, 8'h00);
    endtask

    // Snapshot holds until hundredths is read again; masked write is dropped
    task automatic t_snapshot();
        logic [31:0] v;
        reg_write(5'h02, 8'h07);
        rd_chk("hsec latch", IDX_HSEC, 8'h00);
        reg_write(5'h02, 8'h08);
        rd_chk("min held", 5'h02, 8'h07);
        rd_chk("hsec relatch", IDX_HSEC, 8'h00);
        rd_chk("min fresh", 5'h02, 8'h08);
        bus(1'b1, 5'h02, 8'h09, 4'hE, v);
        rd_chk("hsec relatch", IDX_HSEC, 8'h00);
        rd_chk("masked write", 5'h02, 8'h08);
    endtask

    // Full-day rollover from 28 February, into the 29th or into March, with all periodic sources
    task automatic t_rollover(input logic [7:0] mode, input logic [7:0] hr, input logic [7:0] yr,
                              input logic [7:0] exp_hr, input logic [7:0] exp_mon,
                              input logic [7:0] exp_date);
        logic [31:0] v;
        int n;
        logic [7:0] init [8];
        init = '{8'h63, hr, 8'h3B, 8'h3B, 8'h02, 8'h1C, yr, 8'h06};
        reg_write(IDX_CMD, mode);
        reg_write(IDX_INTCTL, 8'h3F);
        for (int i = 0; i < 8; i++) reg_write(5'(i), init[i]);
        bus(1'b0, IDX_STATUS, 8'h00, 4'hF, v);
        reg_write(IDX_CMD, mode | 8'h18);
        n = 0;
        v = 32'h63;
        while (v === 32'h63 && n < 2000) begin
            bus(1'b0, IDX_HSEC, 8'h00, 4'hF, v);
            n++;
        end
        // Status and then irq trail the step by one register each
        repeat (2) @(posedge clk);
        chk("irq on periodic", {31'h0, irq}, 32'h1);
        reg_write(IDX_CMD, mode);
        rd_chk("status sources", IDX_STATUS, 8'hBF);
        rd_chk("status cleared", IDX_STATUS, 8'h00);
        rd_chk("hour", IDX_HOUR, exp_hr);
        rd_chk("min", 5'h02, 8'h00);
        rd_chk("sec", 5'h03, 8'h00);
        rd_chk("month", 5'h04, exp_mon);
        rd_chk("date", 5'h05, exp_date);
        rd_chk("year", 5'h06, yr);
        rd_chk("weekday", IDX_WDAY, 8'h00);
    endtask

    // Fast crystal setting must not tick in the span where the slow one does
    task automatic t_freq();
        logic [31:0] v;
        reg_write(IDX_HSEC, 8'h00);
        reg_write(IDX_CMD, 8'h0F);
        repeat (1400) @(posedge clk);
        reg_write(IDX_CMD, 8'h07);
        rd_chk("no tick at 4M", IDX_HSEC, 8'h00);
        reg_write(IDX_CMD, 8'h0C);
        repeat (1400) @(posedge clk);
        reg_write(IDX_CMD, 8'h04);
        bus(1'b0, IDX_HSEC, 8'h00, 4'hF, v);
        chk("ticks at 32k", {31'h0, v >= 32'h1 && v <= 32'h2}, 32'h1);
    endtask

    // Alarm two hundredths ahead of the running time
    task automatic t_alarm();
        int n;
        logic [31:0] v;
        logic [7:0] tm [7];
        tm = '{8'h10, 8'h05, 8'h20, 8'h30, 8'h06, 8'h0F, 8'h09};
        reg_write(IDX_CMD, 8'h04);
        reg_write(IDX_INTCTL, 8'h40);
        // Drop the 100 Hz bit left by the crystal scenario
        bus(1'b0, IDX_STATUS, 8'h00, 4'hF, v);
        for (int i = 0; i < 7; i++) reg_write(5'(i), tm[i]);
        for (int i = 0; i < 7; i++) reg_write(IDX_ALARM + 5'(i), (i == 0) ? 8'h12 : tm[i]);
        reg_write(IDX_CMD, 8'h1C);
        n = 0;
        while (irq_alarm !== 1'b1 && n < 8000) begin
            @(posedge clk);
            n++;
        end
        chk("alarm irq", {30'h0, irq_alarm, irq}, 32'h3);
        reg_write(IDX_CMD, 8'h14);
        rd_chk("alarm hsec", IDX_HSEC, 8'h12);
        rd_chk("alarm status", IDX_STATUS, 8'hC0);
    endtask

    // Power loss: reads give 0, writes are dropped, access returns after
    task automatic t_power();
        reg_write(5'h02, 8'h11);
        power_fail <= 1'b1;
        repeat (4) @(posedge clk);
        reg_write(5'h02, 8'h22);
        rd_chk("read in power loss", IDX_HSEC, 8'h00);
        rd_chk("read in power loss", 5'h02, 8'h00);
        power_fail <= 1'b0;
        repeat (4) @(posedge clk);
        rd_chk("hsec relatch", IDX_HSEC, 8'h12);
        rd_chk("write dropped", 5'h02, 8'h11);
    endtask

    // Multiplexed addressing: index captured on the latch strobe, bus address ignored
    task automatic t_latch();
        reg_write(IDX_INTCTL, 8'h80);
        @(posedge clk);
        avs_address <= {IDX_INTCTL, 2'h0};
        addr_latch <= 1'b1;
        @(posedge clk);
        addr_latch <= 1'b0;
        rd_chk("latched index read", 5'h0F, 8'h80);
        reg_write(5'h0F, 8'h00);
        rd_chk("direct index read", IDX_INTCTL, 8'h00);
    endtask

    // Inputs at time zero, reset, then the scenarios
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        avs_address = 7'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hF;
        addr_latch = 1'b0;
        power_fail = 1'b0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        t_reset_map();
        t_snapshot();
        t_rollover(8'h04, 8'h17, 8'h04, 8'h00, 8'h02, 8'h1D);
        t_rollover(8'h00, 8'h8B, 8'h05, 8'h0C, 8'h03, 8'h01);
        t_freq();
        t_alarm();
        t_power();
        t_latch();
        give_verdict();
    end

    // Whole run is near 9k cycles; this span only trips on a hang
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
endmodule
